/* core/cpmc_defines.vh */
// register map, field positions, reset values and timing of the motor core
`ifndef CPMC_DEFINES_VH
`define CPMC_DEFINES_VH
`define CPMC_A_MODE     8'h00
`define CPMC_A_SUBMODE  8'h04
`define CPMC_A_STATUS   8'h08
`define CPMC_A_GAIN     8'h10
`define CPMC_GAIN_STEP  8'h10
`define CPMC_O_KP       8'h00
`define CPMC_O_TN       8'h04
`define CPMC_O_EMAX     8'h08
`define CPMC_O_YMAX     8'h0C
`define CPMC_A_VFF      8'h40
`define CPMC_A_AFF      8'h44
`define CPMC_A_ASCALE   8'h48
`define CPMC_A_VLTFF    8'h4C
`define CPMC_A_VRATED   8'h50
`define CPMC_A_LEG      8'h60
`define CPMC_LEG_STEP   8'h08
`define CPMC_A_LEG_CL   8'h78
`define CPMC_A_LEG_OL   8'h7C
`define CPMC_A_Y_POS    8'h80
`define CPMC_A_Y_VEL    8'h84
`define CPMC_A_Y_CUR    8'h88
`define CPMC_RST_KP     16'h0064
`define CPMC_RST_TN     16'h0010
`define CPMC_RST_EMAX   16'h0400
`define CPMC_RST_YMAX   16'h0400
`define CPMC_RST_VLTFF  16'h03E8
`define CPMC_RST_LEGSEL 16'h0001
`define CPMC_RST_VRATED 16'h0400
`define CPMC_SUB_CL     0
`define CPMC_SUB_POSV   1
`define CPMC_SUB_REALT  5
`define CPMC_MODE_PP    4'h1
`define CPMC_MODE_VEL   4'h2
`define CPMC_MODE_PV    4'h3
`define CPMC_MODE_PT    4'h4
`define CPMC_MODE_HOM   4'h6
`define CPMC_MODE_IP    4'h7
`define CPMC_MODE_CSP   4'h8
`define CPMC_MODE_CSV   4'h9
`define CPMC_MODE_CST   4'hA
`define CPMC_MODE_CD    4'hB
`define CPMC_PCT        48'sd100
`define CPMC_PERMIL     48'sd1000
`define CPMC_PERIOD_NS  16000
`define CPMC_CLK_NS     4
`define CPMC_PERIOD_CYC (`CPMC_PERIOD_NS / `CPMC_CLK_NS)
`endif

/* core/cpmc_core.v */
// cascaded pi motor control core with apb register slave
//
// What this block does
// - three cascaded pi stages: position, velocity, current
// - current stage runs in every mode
// - velocity stage off in real torque or open loop
// - position stage in closed loop only: position modes, or velocity modes with bit1
// - legacy gains default; zero selects new set
// - each stage: gain times error plus integral
// - outputs clamped to speed, current, pwm limit
// - full deviation at 100% gives full output
// - proportional output linear in gain
// - zero reset time clears integral
// - shorter reset time, faster integral growth
// - velocity feed forward added before velocity
// - velocity feed forward only with position stage
// - acceleration feed forward added before current
// - acceleration feed forward off in torque modes
// - voltage feed forward factor resets to 1000
// - voltage feed forward only with velocity stage; zero disables
// - submode bit0 picks open or closed loop
//
// The register addresses and the APB register port were decided locally.
`include "cpmc_defines.vh"
`timescale 1ns/1ps

module cpmc_core (
	input  wire        i_sys_clk,
	input  wire        i_arst_n,
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [7:0]  i_paddr,
	input  wire [31:0] i_pwdata,
	input  wire [3:0]  i_pstrb,
	output reg         o_pready,
	output reg  [31:0] o_prdata,
	output reg         o_pslverr,
	input  wire [15:0] i_tgt_pos,
	input  wire [15:0] i_tgt_torque,
	input  wire [15:0] i_ramp_vel,
	input  wire [15:0] i_ramp_acc,
	input  wire [15:0] i_act_pos,
	input  wire [15:0] i_act_vel,
	input  wire [15:0] i_act_cur,
	output reg  [15:0] o_pwm_duty,
	output reg         o_pwm_valid
);

localparam ST_IDLE = 3'd0;
localparam ST_POS  = 3'd1;
localparam ST_VEL  = 3'd2;
localparam ST_CUR  = 3'd3;
localparam ST_OUT  = 3'd4;

////////////////////////////////////////////////////////////////////////////
// reset release and pin synchronisers

reg         rst_s1_q;
reg         rst_s2_q;
reg [111:0] pin_s1_q;
reg [111:0] pin_s2_q;
wire        rst_n = rst_s2_q;

// release the async reset through two flops
always @(posedge i_sys_clk or negedge i_arst_n) begin
	if (!i_arst_n) begin
		rst_s1_q <= 1'b0;
		rst_s2_q <= 1'b0;
	end else begin
		rst_s1_q <= 1'b1;
		rst_s2_q <= rst_s1_q;
	end
end

// feedback and set point pins pass two flops
always @(posedge i_sys_clk or negedge rst_n) begin
	if (!rst_n) begin
		pin_s1_q <= 112'd0;
		pin_s2_q <= 112'd0;
	end else begin
		pin_s1_q <= {i_tgt_pos, i_tgt_torque, i_ramp_vel, i_ramp_acc,
			i_act_pos, i_act_vel, i_act_cur};
		pin_s2_q <= pin_s1_q;
	end
end

wire [15:0] tgt_pos    = pin_s2_q[111:96];
wire [15:0] tgt_torque = pin_s2_q[95:80];
wire [15:0] ramp_vel   = pin_s2_q[79:64];
wire [15:0] ramp_acc   = pin_s2_q[63:48];
wire [15:0] act_pos    = pin_s2_q[47:32];
wire [15:0] act_vel    = pin_s2_q[31:16];
wire [15:0] act_cur    = pin_s2_q[15:0];

////////////////////////////////////////////////////////////////////////////
// register file

reg  [15:0] rf_q [0:31];
reg         conv_q;
reg  [2:0]  st_q;
reg  [15:0] y_pos_q;
reg  [15:0] y_vel_q;
reg  [15:0] y_cur_q;
wire [4:0]  widx = i_paddr[6:2];
wire        acc  = i_psel & i_penable & ~o_pready;

// reset value of each storage word
function [15:0] rst_val;
	input integer idx;
	reg [7:0] a;
	begin
		a = {idx[5:0], 2'b00};
		rst_val = 16'h0000;
		if (a >= `CPMC_A_GAIN && a < `CPMC_A_VFF) begin
			case ({4'h0, a[3:0]})
			`CPMC_O_KP:   rst_val = `CPMC_RST_KP;
			`CPMC_O_TN:   rst_val = `CPMC_RST_TN;
			`CPMC_O_EMAX: rst_val = `CPMC_RST_EMAX;
			default:      rst_val = `CPMC_RST_YMAX;
			endcase
		end else if (a >= `CPMC_A_LEG && a < `CPMC_A_LEG_CL) begin
			rst_val = a[2] ? `CPMC_RST_TN : `CPMC_RST_KP;
		end else if (a == `CPMC_A_VLTFF) begin
			rst_val = `CPMC_RST_VLTFF;
		end else if (a == `CPMC_A_VRATED) begin
			rst_val = `CPMC_RST_VRATED;
		end else if (a == `CPMC_A_LEG_CL || a == `CPMC_A_LEG_OL) begin
			rst_val = `CPMC_RST_LEGSEL;
		end
	end
endfunction

// decode: storage words below y_pos, outputs read only
wire hit = (i_paddr[1:0] == 2'b00) && (i_paddr <= `CPMC_A_Y_CUR);
wire wr_ok = hit && (i_paddr < `CPMC_A_Y_POS) &&
	(i_paddr != `CPMC_A_STATUS);

// one-shot legacy to new gain copy, then software writes
integer i;
always @(posedge i_sys_clk or negedge rst_n) begin
	if (!rst_n) begin
		for (i = 0; i < 32; i = i + 1) begin
			rf_q[i] <= rst_val(i);
		end
		conv_q <= 1'b0;
	end else if (!conv_q) begin
		for (i = 0; i < 3; i = i + 1) begin
			rf_q[4 + 4 * i] <= rf_q[24 + 2 * i];
			rf_q[5 + 4 * i] <= rf_q[25 + 2 * i];
		end
		conv_q <= 1'b1;
	end else if (acc && i_pwrite && wr_ok) begin
		rf_q[widx] <= {i_pstrb[1] ? i_pwdata[15:8] : rf_q[widx][15:8],
			i_pstrb[0] ? i_pwdata[7:0] : rf_q[widx][7:0]};
	end
end

////////////////////////////////////////////////////////////////////////////
// mode decode

wire [3:0]  mode = rf_q[0][3:0];
wire [15:0] sub  = rf_q[1];
wire closed = sub[`CPMC_SUB_CL];
wire torq = (mode == `CPMC_MODE_PT) || (mode == `CPMC_MODE_CST);
wire vmode = (mode == `CPMC_MODE_VEL) || (mode == `CPMC_MODE_PV) ||
	(mode == `CPMC_MODE_CSV);
wire pmode = (mode == `CPMC_MODE_PP) || (mode == `CPMC_MODE_HOM) ||
	(mode == `CPMC_MODE_IP) || (mode == `CPMC_MODE_CSP) ||
	(mode == `CPMC_MODE_CD);
wire pos_run = closed & (pmode | (vmode & sub[`CPMC_SUB_POSV]));
wire vel_run = closed & ~(torq & sub[`CPMC_SUB_REALT]);
wire leg_act = closed ? (rf_q[30] != 16'h0000) : (rf_q[31] != 16'h0000);
wire [15:0] status = {11'd0, leg_act, st_q != ST_IDLE, vel_run,
	pos_run, closed};

// apb answer one cycle into the access phase
always @(posedge i_sys_clk or negedge rst_n) begin
	if (!rst_n) begin
		o_pready  <= 1'b0;
		o_prdata  <= 32'h0000_0000;
		o_pslverr <= 1'b0;
	end else begin
		o_pready <= acc;
		if (acc) begin
			o_pslverr <= ~hit;
			if (!hit || i_pwrite)
				o_prdata <= 32'h0000_0000;
			else if (i_paddr == `CPMC_A_STATUS)
				o_prdata <= {16'h0000, status};
			else if (i_paddr == `CPMC_A_Y_POS)
				o_prdata <= {16'h0000, y_pos_q};
			else if (i_paddr == `CPMC_A_Y_VEL)
				o_prdata <= {16'h0000, y_vel_q};
			else if (i_paddr == `CPMC_A_Y_CUR)
				o_prdata <= {16'h0000, y_cur_q};
			else
				o_prdata <= {16'h0000, rf_q[widx]};
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// shared pi datapath

// clamp a wide value into +/- lim (lim taken as 15 bits)
function [15:0] sat;
	input signed [47:0] v;
	input [15:0] lim;
	reg signed [47:0] l;
	reg signed [47:0] n;
	begin
		l = {33'd0, lim[14:0]};
		n = -l;
		if (v > l)
			sat = l[15:0];
		else if (v < n)
			sat = n[15:0];
		else
			sat = v[15:0];
	end
endfunction

reg  signed [15:0] integ_q [0:2];
reg  [13:0] tick_q;
wire [1:0]  s = st_q[1:0] - 2'd1;
wire [4:0]  gi = {1'b0, s, 2'b00} + 5'd4;
wire [4:0]  li = {2'b00, s, 1'b0} + 5'd24;
wire [15:0] kp   = leg_act ? rf_q[li] : rf_q[gi];
wire [15:0] tn   = leg_act ? rf_q[li + 5'd1] : rf_q[gi + 5'd1];
wire [15:0] emax = rf_q[gi + 5'd2];
wire [15:0] ymax = rf_q[gi + 5'd3];

reg  [15:0] sp;
reg  [15:0] act;
reg  [15:0] e;
reg  [15:0] integ_n;
reg  [15:0] y;
reg  [15:0] vff_t;
reg  [15:0] aff_t;
reg  [15:0] vlt_t;
reg  [15:0] tq_lim;
reg  signed [47:0] esc;
reg  signed [47:0] emn;
reg  signed [47:0] tmp;

// feed forward terms and set point of the stage in work
always @* begin
	tmp = $signed(ramp_vel) * $signed({32'd0, rf_q[16]});
	vff_t = sat(tmp / `CPMC_PERMIL, 16'h7FFF);
	tmp = $signed({32'd0, rf_q[17]}) * $signed({32'd0, rf_q[18]});
	tmp = (tmp / `CPMC_PERMIL) * $signed(ramp_acc);
	aff_t = torq ? 16'h0000 : sat(tmp, 16'h7FFF);
	tmp = $signed(y_vel_q) * $signed({32'd0, rf_q[20]});
	tmp = (tmp / `CPMC_PERMIL) * $signed({32'd0, rf_q[19]});
	vlt_t = sat(tmp / `CPMC_PERMIL, 16'h7FFF);
	tq_lim = y_vel_q[15] ? -y_vel_q : y_vel_q;
	case (st_q)
	ST_POS: begin
		sp  = tgt_pos;
		act = act_pos;
	end
	ST_VEL: begin
		tmp = $signed(y_pos_q) + $signed(vff_t);
		sp  = pos_run ? sat(tmp, 16'h7FFF) : ramp_vel;
		act = act_vel;
	end
	ST_CUR: begin
		if (!closed)
			sp = rf_q[15]; // open loop drives the pwm limit
		else if (torq && !vel_run)
			sp = tgt_torque;
		else if (torq)
			sp = sat($signed(tgt_torque), tq_lim);
		else
			sp = y_vel_q;
		act = act_cur;
	end
	default: begin
		sp  = 16'h0000;
		act = 16'h0000;
	end
	endcase
end

// proportional and integral parts of one stage
always @* begin
	tmp = $signed(sp) - $signed(act);
	e = sat(tmp, emax);
	emn = $signed({32'd0, (emax == 16'h0000) ? 16'h0001 : emax});
	esc = ($signed(e) * $signed({32'd0, ymax})) / emn;
	tmp = (esc * $signed({32'd0, kp})) / `CPMC_PCT;
	if (tn == 16'h0000) begin
		integ_n = 16'h0000;
	end else begin
		integ_n = sat($signed(integ_q[s]) + esc / $signed({32'd0, tn}),
			ymax);
	end
	y = sat(tmp + $signed(integ_n), ymax);
end

////////////////////////////////////////////////////////////////////////////
// control cycle sequencer

// one pass per control period, outermost stage first
always @(posedge i_sys_clk or negedge rst_n) begin
	if (!rst_n) begin
		st_q        <= ST_IDLE;
		tick_q      <= 14'd0;
		y_pos_q     <= 16'h0000;
		y_vel_q     <= 16'h0000;
		y_cur_q     <= 16'h0000;
		integ_q[0]  <= 16'h0000;
		integ_q[1]  <= 16'h0000;
		integ_q[2]  <= 16'h0000;
		o_pwm_duty  <= 16'h0000;
		o_pwm_valid <= 1'b0;
	end else begin
		o_pwm_valid <= 1'b0;
		if (tick_q == `CPMC_PERIOD_CYC - 1)
			tick_q <= 14'd0;
		else
			tick_q <= tick_q + 14'd1;
		case (st_q)
		ST_IDLE: begin
			if (tick_q == 14'd0 && conv_q)
				st_q <= ST_POS;
		end
		ST_POS: begin
			y_pos_q    <= pos_run ? y : 16'h0000;
			integ_q[0] <= pos_run ? integ_n : 16'h0000;
			st_q       <= ST_VEL;
		end
		ST_VEL: begin
			y_vel_q    <= vel_run ? sat($signed(y) + $signed(aff_t),
				ymax) : 16'h0000;
			integ_q[1] <= vel_run ? integ_n : 16'h0000;
			st_q       <= ST_CUR;
		end
		ST_CUR: begin
			y_cur_q    <= sat($signed(y) + $signed(vlt_t), ymax);
			integ_q[2] <= integ_n;
			st_q       <= ST_OUT;
		end
		ST_OUT: begin
			o_pwm_duty  <= y_cur_q;
			o_pwm_valid <= 1'b1;
			st_q        <= ST_IDLE;
		end
		default: st_q <= ST_IDLE;
		endcase
	end
end

endmodule

/* bench/cpmc_chk.sv */
// timing checks on the apb slave and the pwm output of the motor core
`timescale 1ns/1ps
module cpmc_chk (
	input wire logic        i_sys_clk,
	input wire logic        i_arst_n,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic [7:0]  i_paddr,
	input wire logic        o_pready,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pslverr,
	input wire logic [15:0] o_pwm_duty,
	input wire logic        o_pwm_valid
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	logic acc;
	// access phase still waiting for its answer
	assign acc = i_psel && i_penable && !o_pready;
	a_ready_wait: assert property (acc |=> o_pready)
		else $error("ready missing one cycle after access");
	a_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("ready longer than one cycle");
	a_ready_cause: assert property (o_pready |-> $past(i_psel && i_penable))
		else $error("ready without an access");
	a_err_range: assert property (acc && i_paddr > 8'h88
		|=> o_pslverr && o_prdata == 32'h0)
		else $error("address above map not refused");
	a_err_align: assert property (acc && i_paddr[1:0] != 2'b00 |=> o_pslverr)
		else $error("unaligned address not refused");
	a_ok_mapped: assert property (acc && i_paddr <= 8'h88
		&& i_paddr[1:0] == 2'b00 |=> !o_pslverr && o_prdata[31:16] == 16'h0)
		else $error("mapped access refused or upper half set");
	a_pwm_pulse: assert property (o_pwm_valid |=> !o_pwm_valid)
		else $error("pwm valid longer than one cycle");
	a_duty_hold: assert property (!o_pwm_valid |-> $stable(o_pwm_duty))
		else $error("duty changed without valid");
	cover property (acc && i_paddr > 8'h88);
	cover property (o_pready && !o_pslverr);
	cover property (o_pwm_valid && o_pwm_duty != 16'h0);
endmodule
bind cpmc_core cpmc_chk u_chk (.i_sys_clk, .i_arst_n, .i_psel, .i_penable,
	.i_paddr, .o_pready, .o_prdata, .o_pslverr, .o_pwm_duty, .o_pwm_valid);

/* bench/cpmc_motor.sv */
// power stage and feedback model: winding current follows half the duty
`timescale 1ns/1ps
module cpmc_motor (
	input  wire logic        i_sys_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_slow,
	input  wire logic [15:0] i_duty,
	input  wire logic        i_valid,
	output logic      [15:0] o_pos,
	output logic      [15:0] o_vel,
	output logic      [15:0] o_cur
);
	logic skip_q;
	// current settles each pwm update, or every other one when slow
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			{o_pos, o_vel, o_cur, skip_q} <= '0;
		end else if (i_valid) begin
			skip_q <= i_slow && !skip_q;
			if (!(i_slow && !skip_q))
				o_cur <= {i_duty[15], i_duty[15:1]};
			o_vel <= o_vel + {{4{o_cur[15]}}, o_cur[15:4]};
			o_pos <= o_pos + o_vel;
		end
	end
endmodule

/* bench/testbench.sv */
// self-checking bench for the cascaded motor control core
`timescale 1ns/1ps
module testbench;
	logic        clk, arst_n, psel, penable, pwrite, slow, valid, err;
	logic        pready, pslverr;
	logic [7:0]  paddr;
	logic [3:0]  pstrb;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] tpos, ttq, rvel, racc, apos, avel, acur, duty;
	int          mismatches, compares, cyc, kp, em, y, m, s, st;
	int          modes[10] = '{1, 2, 3, 4, 6, 7, 8, 9, 10, 11};
	cpmc_core uut (.i_sys_clk(clk), .i_arst_n(arst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .i_tgt_pos(tpos),
		.i_tgt_torque(ttq), .i_ramp_vel(rvel), .i_ramp_acc(racc),
		.i_act_pos(apos), .i_act_vel(avel), .i_act_cur(acur),
		.o_pwm_duty(duty), .o_pwm_valid(valid));
	cpmc_motor u_motor (.i_sys_clk(clk), .i_arst_n(arst_n), .i_slow(slow),
		.i_duty(duty), .i_valid(valid), .o_pos(apos), .o_vel(avel),
		.o_cur(acur));
	////////////////////////////////////////////////////////////////
	task automatic results();
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until ready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	////////////////////////////////////////////////////////////////
	// clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// random set points and the hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		{tpos, ttq} <= $urandom;
		{rvel, racc} <= $urandom;
		if (cyc == 90000) begin
			mismatches++;
			results();
		end
	end
	// main sequence
	initial begin
		{psel, penable, pwrite, slow, arst_n} = '0;
		{tpos, ttq, rvel, racc} = '0;
		paddr = 8'h0;
		pwdata = 32'h0;
		pstrb = 4'hF;
		st = $urandom(18);
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rdk(8'h4C, 32'h03E8);
		rdk(8'h78, 32'h1);
		rdk(8'h7C, 32'h1);
		apb(1'b0, 8'h60, 32'h0);
		st = rd;
		rdk(8'h10, st);
		rdk(8'h8C, 32'h0);
		chk(err, 1'b1);
		apb(1'b0, 8'h02, 32'h0);
		chk(err, 1'b1);
		apb(1'b0, 8'h08, 32'h0);
		st = rd & 32'hF7;
		apb(1'b1, 8'h08, ~st);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd & 32'hF7, st);
		foreach (modes[i])
			for (s = 0; s < 4; s++) begin
				m = modes[i];
				apb(1'b1, 8'h00, m);
				apb(1'b1, 8'h04, (s[1] << 5) | (s[0] << 1) | 1);
				apb(1'b0, 8'h08, 32'h0);
				chk(rd[2:0], {!((m == 4 || m == 10) && s[1]),
					(m inside {1, 6, 7, 8, 11}) ||
					((m inside {2, 3, 9}) && s[0]), 1'b1});
			end
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h00, 32'h2);
		apb(1'b1, 8'h7C, 32'h0);
		apb(1'b1, 8'h34, 32'h0);
		apb(1'b1, 8'h44, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd[0], 1'b0);
		repeat (8) begin
			kp = $urandom % 251;
			em = 256 + $urandom % 1792;
			slow <= $urandom % 2;
			apb(1'b1, 8'h30, kp);
			apb(1'b1, 8'h38, em);
			@(posedge clk iff valid === 1'b1);
			@(posedge clk iff valid === 1'b1);
			m = 1024 - acur;
			if (m > em)
				m = em; // deviation clamps at its maximum
			y = m * 1024 / em * kp / 100;
			chk(duty, y > 1024 ? 1024 : y);
		end
		results();
	end
endmodule
